// *** shared/fbo_pkg.sv ***
package fbo_pkg;

  // ************************************************************
  // Bus timing (ns) and derived cycle counts at 250 MHz
  // ************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_ACC_NS = 100;
  localparam int T_WP_NS = 50;
  localparam int T_WPH_NS = 30;
  localparam int T_RH_NS = 50;
  localparam int SLEEP_EXTRA_NS = 30;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RH_CYC = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_CYC =
    (T_ACC_NS + SLEEP_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // ************************************************************
  // Address and data layout
  // ************************************************************
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int LSB_PIN = 15;

  typedef enum logic [1:0] {
    FBO_OP_READ,
    FBO_OP_WRITE,
    FBO_OP_RESET
  } fbo_op_e;

  typedef struct packed {
    fbo_op_e op;
    logic width_select;
    logic byte_lsb_address;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fbo_req_s;

  typedef struct packed {
    logic chip_select_n;
    logic output_enable_n;
    logic write_enable_n;
    logic reset_pin_n;
    logic width_select;
  } fbo_ctl_s;

  localparam fbo_ctl_s CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage : fbo_pkg

// *** verilog/fbo_host.sv ***
`timescale 1ns/10ps
module fbo_host
  import fbo_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire fbo_req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic asleep,
  output fbo_ctl_s ctl,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] flash_data_out,
  output logic [DATA_W-1:0] flash_data_oe_n,
  input wire logic [DATA_W-1:0] flash_data_in
);

  // ************************************************************
  // Sequencer
  // ************************************************************
  typedef enum logic [2:0] {
    S_IDLE, S_READ, S_WR_PULSE, S_WR_HOLD, S_RST_PULSE, S_RST_REC
  } fbo_state_e;

  fbo_state_e state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] idle_r, idle_nxt;
  fbo_ctl_s ctl_r, ctl_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic [DATA_W-1:0] oe_r, oe_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic ready_r, ready_nxt;
  logic sleep_r, sleep_nxt;

  function automatic logic [DATA_W-1:0] fbo_mask(input logic wide);
    fbo_mask = wide ? {DATA_W{1'b1}} : {{(DATA_W-BYTE_W){1'b0}},
                                        {BYTE_W{1'b1}}};
  endfunction : fbo_mask

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ctl_nxt = ctl_r;
    addr_nxt = addr_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    ready_nxt = 1'b0;
    idle_nxt = idle_r;
    sleep_nxt = sleep_r;
    case (state_r)
      S_IDLE: begin
        ready_nxt = 1'b1;
        // Chip select high with reset high: device standby
        ctl_nxt.chip_select_n = 1'b1;
        ctl_nxt.output_enable_n = 1'b1;
        ctl_nxt.write_enable_n = 1'b1;
        oe_nxt = '1;
        // Address held: device drops into sleep regardless of controls
        if (idle_r != CNT_W'(SLEEP_CYC)) begin
          idle_nxt = idle_r + 1'b1;
        end else begin
          sleep_nxt = 1'b1;
        end
        if (req_valid && ready_r) begin
          ready_nxt = 1'b0;
          ctl_nxt.width_select = req.width_select;
          addr_nxt = req.addr;
          idle_nxt = '0;
          sleep_nxt = 1'b0;
          cnt_nxt = '0;
          case (req.op)
            FBO_OP_READ: begin
              ctl_nxt.chip_select_n = 1'b0;
              ctl_nxt.output_enable_n = 1'b0;
              if (!req.width_select) begin
                // Pin 15 carries lsb address in byte mode
                oe_nxt[LSB_PIN] = 1'b0;
                dout_nxt = {req.byte_lsb_address, {(DATA_W-1){1'b0}}};
              end
              state_nxt = S_READ;
            end
            FBO_OP_WRITE: begin
              // Output enable stays high for writes
              ctl_nxt.chip_select_n = 1'b0;
              ctl_nxt.write_enable_n = 1'b0;
              oe_nxt = ~fbo_mask(req.width_select);
              dout_nxt = req.wdata & fbo_mask(req.width_select);
              if (!req.width_select) begin
                oe_nxt[LSB_PIN] = 1'b0;
                dout_nxt[LSB_PIN] = req.byte_lsb_address;
              end
              state_nxt = S_WR_PULSE;
            end
            default: begin
              ctl_nxt.reset_pin_n = 1'b0;
              state_nxt = S_RST_PULSE;
            end
          endcase
        end
      end
      S_READ: begin
        // Full access time every read, also from standby
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(ACC_CYC - 1)) begin
          rdata_nxt = flash_data_in & fbo_mask(ctl_r.width_select);
          rvalid_nxt = 1'b1;
          ctl_nxt.output_enable_n = 1'b1;
          ctl_nxt.chip_select_n = 1'b1;
          oe_nxt = '1;
          cnt_nxt = '0;
          state_nxt = S_IDLE;
        end
      end
      S_WR_PULSE: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(WP_CYC - 1)) begin
          ctl_nxt.write_enable_n = 1'b1;
          ctl_nxt.chip_select_n = 1'b1; // Operation continues
          cnt_nxt = '0;
          state_nxt = S_WR_HOLD;
        end
      end
      S_WR_HOLD: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(WPH_CYC - 1)) begin
          oe_nxt = '1;
          rvalid_nxt = 1'b1; // One write cycle of a sequence
          cnt_nxt = '0;
          state_nxt = S_IDLE;
        end
      end
      S_RST_PULSE: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(RH_CYC - 1)) begin
          ctl_nxt.reset_pin_n = 1'b1;
          cnt_nxt = '0;
          state_nxt = S_RST_REC;
        end
      end
      S_RST_REC: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(RH_CYC - 1)) begin
          rvalid_nxt = 1'b1;
          cnt_nxt = '0;
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= S_IDLE;
      cnt_r <= '0;
      idle_r <= '0;
      ctl_r <= CTL_IDLE;
      addr_r <= '0;
      dout_r <= '0;
      oe_r <= '1;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
      ready_r <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      idle_r <= idle_nxt;
      ctl_r <= ctl_nxt;
      addr_r <= addr_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      ready_r <= ready_nxt;
      sleep_r <= sleep_nxt;
    end
  end

  assign req_ready = ready_r;
  assign rsp_valid = rvalid_r;
  assign rsp_data = rdata_r;
  assign asleep = sleep_r;
  assign ctl = ctl_r;
  assign flash_addr = addr_r;
  assign flash_data_out = dout_r;
  assign flash_data_oe_n = oe_r;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_no_oe_we;
    @(posedge clk_sys) disable iff (!reset_n)
      !(!ctl_r.output_enable_n && !ctl_r.write_enable_n);
  endproperty
  a_no_oe_we: assert property (p_no_oe_we)
    else $error("oe and we low");

  property p_read_pins;
    @(posedge clk_sys) disable iff (!reset_n)
      !ctl_r.output_enable_n |-> !ctl_r.chip_select_n && oe_r[7:0] == 8'hFF;
  endproperty
  a_read_pins: assert property (p_read_pins)
    else $error("bad read pins");

  property p_write_pins;
    @(posedge clk_sys) disable iff (!reset_n)
      !ctl_r.write_enable_n |-> !ctl_r.chip_select_n && ctl_r.output_enable_n;
  endproperty
  a_write_pins: assert property (p_write_pins)
    else $error("bad write");

  property p_read_len;
    @(posedge clk_sys) disable iff (!reset_n)
      $fell(ctl_r.output_enable_n) |->
        !ctl_r.output_enable_n [*8] ##0 (!ctl_r.output_enable_n)[*1];
  endproperty
  a_read_len: assert property (p_read_len) else $error("short read");

  property p_read_rsp;
    @(posedge clk_sys) disable iff (!reset_n)
      $fell(ctl_r.output_enable_n) |-> ##25 rsp_valid;
  endproperty
  a_read_rsp: assert property (p_read_rsp) else $error("read late");

  property p_byte_float;
    @(posedge clk_sys) disable iff (!reset_n)
      !ctl_r.chip_select_n && !ctl_r.width_select |->
        oe_r[14:8] == 7'h7F && !oe_r[15];
  endproperty
  a_byte_float: assert property (p_byte_float)
    else $error("byte pins");

  property p_rst_hold;
    @(posedge clk_sys) disable iff (!reset_n)
      $fell(ctl_r.reset_pin_n) |-> !ctl_r.reset_pin_n [*8];
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset short");

  property p_sleep;
    @(posedge clk_sys) disable iff (!reset_n)
      asleep |-> idle_r == CNT_W'(SLEEP_CYC) && state_r == S_IDLE;
  endproperty
  a_sleep: assert property (p_sleep) else $error("early sleep");

  c_read: cover property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(ctl_r.output_enable_n));
  c_write: cover property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(ctl_r.write_enable_n));
  c_reset: cover property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(ctl_r.reset_pin_n));
  c_sleep: cover property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(asleep));

endmodule : fbo_host

// *** verification/fbo_flash_model.sv ***
`timescale 1ns/10ps
// ****************************************
// Flash device seen from its pins
// ****************************************
module fbo_flash_model
  import fbo_pkg::*;
#(
  parameter logic [DATA_W-1:0] PAT = 16'h5A3C
)
(
  input wire logic clk_sys,
  input wire fbo_ctl_s ctl,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_data_out,
  input wire logic [DATA_W-1:0] flash_data_oe_n,
  output logic [DATA_W-1:0] flash_data_in
);
  logic [DATA_W-1:0] word;
  logic [DATA_W-1:0] junk = 16'h3C96;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_data;
  logic rd;
  logic wr;
  // Array read is fixed: commands only latch cmd_addr and cmd_data, none changes it
  assign word = flash_addr[15:0] ^ PAT;
  assign rd = !ctl.chip_select_n && !ctl.output_enable_n &&
    ctl.write_enable_n && ctl.reset_pin_n;
  assign wr = !ctl.chip_select_n && !ctl.write_enable_n &&
    ctl.reset_pin_n;
  always @(posedge clk_sys) begin
    junk <= ~junk;
    if (wr) begin
      cmd_addr <= flash_addr;
      cmd_data <= flash_data_out;
    end
  end
  always_comb begin
    flash_data_in = junk;
    if (rd && ctl.width_select) begin
      flash_data_in = word;
    end else if (rd) begin
      flash_data_in[7:0] = flash_data_out[LSB_PIN] ? word[15:8] :
        word[7:0];
    end
  end
endmodule : fbo_flash_model

// *** verification/flash_bus_operation_control_test.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  mismatches++; $display("FAIL %s exp %h got %h", n, e, g); end end
// ****************************************
// Bench top
// ****************************************
module flash_bus_operation_control_test;
  import fbo_pkg::*;
  localparam logic [15:0] PAT = 16'h5A3C;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  fbo_req_s req = '0;
  logic req_ready, rsp_valid, asleep;
  logic [DATA_W-1:0] rsp_data, flash_data_out, flash_data_oe_n, flash_data_in;
  logic [ADDR_W-1:0] flash_addr;
  fbo_ctl_s ctl;
  int mismatches = 0;
  int checks_done = 0;
  logic [15:0] exp_q[$];
  logic [15:0] last_rd = 16'h0000;
  logic [18:0] a;
  logic [15:0] w;
  logic [15:0] exp_v;
  logic [15:0] m;
  logic [15:0] cd;
  logic ws_b;
  always #2 clk_sys = ~clk_sys;
  fbo_host u_fbo_host (.clk_sys(clk_sys), .reset_n(reset_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .asleep(asleep),
    .ctl(ctl), .flash_addr(flash_addr), .flash_data_out(flash_data_out),
    .flash_data_oe_n(flash_data_oe_n), .flash_data_in(flash_data_in));
  fbo_flash_model #(.PAT(PAT)) u_fbo_flash_model (.clk_sys(clk_sys),
    .ctl(ctl), .flash_addr(flash_addr), .flash_data_out(flash_data_out),
    .flash_data_oe_n(flash_data_oe_n), .flash_data_in(flash_data_in));
  always @(negedge clk_sys) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK("rsp_note", 1'b1, 1'b0)
      end else begin
        exp_v = exp_q.pop_front();
        `CHK("rsp_data", exp_v, rsp_data)
      end
    end
  end
  task automatic do_op(input fbo_op_e op, input logic ws, input logic lsb,
    input logic [18:0] ad, input logic [15:0] d, input logic [15:0] e);
    int n;
    n = 0;
    if (op == FBO_OP_READ) last_rd = e;
    exp_q.push_back(last_rd);
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge clk_sys); #1; n++;
    end
    req_valid = 1'b1;
    req = '{op, ws, lsb, ad, d};
    @(posedge clk_sys); #1;
    req_valid = 1'b0;
    `CHK("width_pin", ws, ctl.width_select)
    case (op)
      FBO_OP_READ: `CHK("ctl", 4'h3, ctl[4:1])
      FBO_OP_WRITE: `CHK("ctl", 4'h5, ctl[4:1])
      default: `CHK("rst_pin", 1'b0, ctl.reset_pin_n)
    endcase
    if (op != FBO_OP_RESET && !ws)
      `CHK("lsb", lsb, flash_data_out[15])
    n = 0;
    while (rsp_valid !== 1'b1 && n < 100) begin
      @(posedge clk_sys); #1; n++;
    end
    case (op)
      FBO_OP_READ: `CHK("lat", ACC_CYC, n)
      FBO_OP_WRITE: `CHK("lat", WP_CYC + WPH_CYC, n)
      default: `CHK("lat", RH_CYC + RH_CYC, n)
    endcase
    @(posedge clk_sys); #1;
  endtask : do_op
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  initial begin
    #80000;
    mismatches++;
    final_report();
  end
  initial begin
    void'($urandom(50286));
    repeat (3) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      a = 19'($urandom);
      do_op(FBO_OP_READ, 1'b1, 1'b0, a, 16'h0000, a[15:0] ^ PAT);
    end
    $display("word read test done");
    for (int i = 0; i < 4; i++) begin
      a = 19'($urandom);
      w = a[15:0] ^ PAT;
      do_op(FBO_OP_READ, 1'b0, i[0], a, 16'h0000,
        {8'h00, i[0] ? w[15:8] : w[7:0]});
    end
    $display("byte read test done");
    for (int i = 0; i < 4; i++) begin
      a = 19'($urandom);
      w = 16'($urandom);
      ws_b = (i < 2);
      m = ws_b ? 16'hFFFF : 16'h80FF;
      cd = ws_b ? w : {i[0], 7'h00, w[7:0]};
      do_op(FBO_OP_WRITE, ws_b, i[0], a, w, 16'h0000);
      `CHK("cmd_addr", a, u_fbo_flash_model.cmd_addr)
      `CHK("cmd_data", cd & m, u_fbo_flash_model.cmd_data & m)
    end
    do_op(FBO_OP_READ, 1'b1, 1'b0, a, 16'h0000, a[15:0] ^ PAT);
    $display("command write test done");
    do_op(FBO_OP_RESET, 1'b1, 1'b0, a, 16'h0000, 16'h0000);
    `CHK("idle_oe_n", 16'hFFFF, flash_data_oe_n)
    do_op(FBO_OP_READ, 1'b1, 1'b0, a, 16'h0000, a[15:0] ^ PAT);
    $display("reset test done");
    `CHK("awake", 1'b0, asleep)
    repeat (SLEEP_CYC + 4) @(posedge clk_sys);
    #1;
    `CHK("asleep", 1'b1, asleep)
    a = a ^ 19'h00101;
    do_op(FBO_OP_READ, 1'b1, 1'b0, a, 16'h0000, a[15:0] ^ PAT);
    $display("sleep test done");
    repeat (4) @(posedge clk_sys);
    final_report();
  end
endmodule : flash_bus_operation_control_test
